// ===== bench/daisy_chain_comm_fault_flags_tb.sv
// Self-checking bench of the communication fault flag block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin err_total++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module daisy_chain_comm_fault_flags_tb;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, busy = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, ev = 32'h0;
   logic        pready, pslverr, irq, err;
   logic [1:0]  is_resp = 2'h0, val = 2'h0, drop = 2'h0, win, lhi, llo, pen;
   logic [9:0]  idx;
   logic [7:0]  r8;
   logic [4:0]  c;
   logic [4:0]  tbl [4] = '{5'h0c, 5'h1a, 5'h15, 5'h1b};
   int          err_total = 0, comparisons = 0, cyc = 0, seed = 35310;
   dcf_top dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .host_tx_busy(busy), .host_break(ev[0]), .host_new_cmd(ev[1]), .host_fwd_read(ev[2]),
      .host_resp_done(ev[3]), .link_frame_start(ev[5:4]), .link_frame_is_resp(is_resp),
      .link_frame_is_read(ev[30:29]), .link_frame_end(ev[7:6]), .link_crc_err(ev[9:8]),
      .link_byte_err(ev[11:10]), .link_init_err(ev[13:12]), .up_phys_err(ev[19:16]),
      .low_phys_err(ev[23:20]), .link_bit_window(win), .link_line_hi(lhi), .link_line_lo(llo),
      .link_fwd_read(ev[15:14]), .nvm_load_err(ev[26:24]), .irq(irq), .link_process_en(pen));
   dcf_far_end far (.clk(clk), .srst(srst), .bit_req(ev[28:27]), .bit_val(val), .bit_drop(drop),
      .bit_window(win), .line_hi(lhi), .line_lo(llo));
   initial forever #50 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         report_and_stop();
      end
   end
   task automatic apb(input logic wr, input logic [9:0] ix, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {ix, 2'b00};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // Wait for the edge at which ready is sampled high; data taken there
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string nm, input logic [9:0] ix, input logic [31:0] ex);
      apb(1'b0, ix, 32'h0);
      `CHK(nm, ex, rd)
   endtask
   task automatic pulse(input int b, input logic [3:0] v);
      @(posedge clk);
      ev[b +: 4] <= v;
      @(posedge clk);
      ev <= 32'h0;
      repeat (3) @(posedge clk);
   endtask
   task automatic irq_is(input logic ex);
      @(negedge clk);
      `CHK("irq", ex, irq)
   endtask
   function automatic logic [31:0] discard_exp(input logic [4:0] cv);
      logic off;
      off = cv[dcf_pkg::CTRL_BASE] ? !cv[dcf_pkg::CTRL_HOST_TX]
          : !cv[cv[dcf_pkg::CTRL_DIR] ? dcf_pkg::CTRL_UP_TX : dcf_pkg::CTRL_LOW_TX];
      return {27'h0, off, 4'h0};
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      for (int i = 0; i < 18; i++) begin
         idx = dcf_pkg::IDX_HOST_TR + 10'(i);
         chk("reset", idx, idx == dcf_pkg::IDX_CTRL ? 32'(dcf_pkg::CTRL_RESET) : 32'h0);
         `CHK("slverr", (idx > dcf_pkg::IDX_NVM && idx < dcf_pkg::IDX_CTRL), err)
      end
      r8 = 8'($random(seed));
      apb(1'b1, 10'h2a5, {24'h0, r8});
      `CHK("slverr w", 1'b1, err)
      apb(1'b1, dcf_pkg::IDX_UP_PHYS, {24'h0, r8});
      chk("ro write", dcf_pkg::IDX_UP_PHYS, 32'h0);
      $display("test registers done");
      pulse(0, 4'h1);
      chk("break idle", dcf_pkg::IDX_HOST_TR, 32'h0);
      busy <= 1'b1;
      pulse(0, 4'h1);
      busy <= 1'b0;
      chk("break busy", dcf_pkg::IDX_HOST_TR, 32'h2);
      apb(1'b1, dcf_pkg::IDX_STAT, 32'h3ff);
      for (int k = 0; k < 2; k++) begin
         is_resp <= 2'(k);
         pulse(4, 4'h1);
         pulse(4, 4'h1);
         chk("sof", dcf_pkg::IDX_UP_RC + 10'(k), 32'h8);
         pulse(6, 4'h1);
         apb(1'b1, dcf_pkg::IDX_STAT, 32'h3ff);
      end
      $display("test frame start done");
      is_resp <= 2'h3;
      for (int i = 0; i < 8; i++) begin
         c = i < 4 ? tbl[i] : 5'($random(seed));
         apb(1'b1, dcf_pkg::IDX_CTRL, {27'h0, c});
         pulse(4 + c[0], 4'h1);
         pulse(6 + c[0], 4'h1);
         chk("discard", dcf_pkg::IDX_UP_RSP + 10'(4 * c[0]), discard_exp(c));
         apb(1'b1, dcf_pkg::IDX_STAT, 32'h3ff);
      end
      apb(1'b1, dcf_pkg::IDX_CTRL, 32'h1c);
      for (int p = 0; p < 2; p++) begin
         r8 = 8'($random(seed));
         pulse(16 + 4 * p, r8[3:0]);
         chk("phys", dcf_pkg::IDX_UP_PHYS + 10'(4 * p), {28'h0, r8[3:0]});
         apb(1'b1, dcf_pkg::IDX_STAT, 32'h3ff);
         val <= r8[5:4];
         pulse(27 + p, 4'h1);
         repeat (8) @(posedge clk);
         chk("bit seen", dcf_pkg::IDX_UP_PHYS + 10'(4 * p), 32'h0);
         drop <= 2'(1 << p);
         pulse(27 + p, 4'h1);
         repeat (8) @(posedge clk);
         drop <= 2'h0;
         chk("bit miss", dcf_pkg::IDX_UP_PHYS + 10'(4 * p), 32'h10);
      end
      $display("test link bits done");
      pulse(1, 4'h1);
      chk("wait idle", dcf_pkg::IDX_UP_TR, 32'h0);
      pulse(14, 4'h1);
      pulse(0, 4'h1);
      chk("wait up", dcf_pkg::IDX_UP_TR, 32'h1);
      pulse(15, 4'h1);
      pulse(1, 4'h1);
      chk("wait low", dcf_pkg::IDX_LOW_TR, 32'h1);
      apb(1'b1, dcf_pkg::IDX_STAT, 32'h3ff);
      is_resp <= 2'h0;
      pulse(12, 4'h1);
      `CHK("hunt", 1'b0, pen[0])
      pulse(8, 4'h1);
      chk("hunt rc", dcf_pkg::IDX_UP_RC, 32'h20);
      pulse(4, 4'h1);
      `CHK("hunt end", 1'b1, pen[0])
      pulse(6, 4'h1);
      pulse(13, 4'h1);
      `CHK("hunt low", 1'b0, pen[1])
      pulse(5, 4'h1);
      `CHK("hunt low end", 1'b1, pen[1])
      apb(1'b1, dcf_pkg::IDX_STAT, 32'h3ff);
      $display("test wait and hunt done");
      r8 = 8'($random(seed));
      apb(1'b1, dcf_pkg::IDX_MASK, 32'h200);
      pulse(24, {1'b0, r8[2:0] | 3'h1});
      chk("nvm", dcf_pkg::IDX_NVM, {29'h0, r8[2:0] | 3'h1});
      irq_is(1'b1);
      apb(1'b1, dcf_pkg::IDX_MASK, 32'h0);
      irq_is(1'b0);
      apb(1'b1, dcf_pkg::IDX_MASK, 32'h200);
      irq_is(1'b1);
      chk("stat", dcf_pkg::IDX_STAT, 32'h200);
      apb(1'b1, dcf_pkg::IDX_STAT, 32'h200);
      irq_is(1'b0);
      chk("nvm clr", dcf_pkg::IDX_NVM, 32'h0);
      $display("test interrupt done");
      report_and_stop();
   end
endmodule

// ===== bench/dcf_far_end.sv
// Far-side link model making bit windows and line levels
`timescale 1ns/1ps
module dcf_far_end (
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic [1:0] bit_req,
   input  wire logic [1:0] bit_val,
   input  wire logic [1:0] bit_drop,
   output logic      [1:0] bit_window,
   output logic      [1:0] line_hi,
   output logic      [1:0] line_lo
);
   logic [2:0] cnt_r [2];
   always_ff @(posedge clk) begin
      for (int i = 0; i < 2; i++) begin
         if (srst)
            cnt_r[i] <= 3'h0;
         else if (bit_req[i])
            cnt_r[i] <= 3'h6;
         else if (cnt_r[i] != 3'h0)
            cnt_r[i] <= cnt_r[i] - 3'h1;
      end
   end
   // Level shows early so that it clears the synchroniser before the window closes
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         bit_window[i] = cnt_r[i] != 3'h0;
         line_hi[i] = cnt_r[i] == 3'h5 && bit_val[i] && !bit_drop[i];
         line_lo[i] = cnt_r[i] == 3'h5 && !bit_val[i] && !bit_drop[i];
      end
   end
endmodule

// ===== bench/dcf_top_asserts.sv
// Port checker of the communication fault flag block
`timescale 1ns/1ps
module dcf_top_asserts (
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        irq,
   input wire logic [1:0]  link_init_err,
   input wire logic [1:0]  link_frame_start,
   input wire logic [1:0]  link_process_en
);
   logic wr_acc;
   assign wr_acc = psel && penable && pready && pwrite;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_hunt_up;
      !link_process_en[0] ##0 !link_init_err[0];
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   a_ready_after_setup: assert property (s_setup |=> pready) else $error("no ready after setup");
   a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
   a_slverr_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
   a_error_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read not zero");
   a_upper_bits_zero: assert property (pready && !pwrite |-> prdata[31:10] == 22'h0)
      else $error("unused read bits set");
   a_reset_quiet: assert property (@(posedge clk) disable iff (1'b0)
      srst |=> !irq && !pready && link_process_en == 2'b11) else $error("outputs not reset");
   a_irq_fall_cause: assert property ($fell(irq) |-> $past(wr_acc) || $past(wr_acc, 2))
      else $error("irq fell without a write");
   a_hunt_enter_up: assert property (link_init_err[0] |=> !link_process_en[0])
      else $error("upper port not hunting");
   a_hunt_enter_low: assert property (link_init_err[1] |=> !link_process_en[1])
      else $error("lower port not hunting");
   a_hunt_hold_up: assert property (s_hunt_up ##0 !link_frame_start[0] |=> !link_process_en[0])
      else $error("hunt ended early");
   a_hunt_exit_up: assert property (s_hunt_up ##0 link_frame_start[0] |=> link_process_en[0])
      else $error("hunt not ended by frame start");
endmodule
bind dcf_top dcf_top_asserts u_chk (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
   .link_init_err(link_init_err), .link_frame_start(link_frame_start),
   .link_process_en(link_process_en));

// ===== rtl/dcf_link_port.sv
// Fault flags of one daisy-chain link port
`timescale 1ns/1ps
module dcf_link_port #(
   parameter bit UPPER = 1'b1
) (
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       dir_sel,
   input  wire logic       cmd_tx_dis,
   input  wire logic       rsp_tx_dis,
   input  wire logic       frame_start,
   input  wire logic       frame_is_resp,
   input  wire logic       frame_is_read,
   input  wire logic       frame_end,
   input  wire logic       crc_err,
   input  wire logic       byte_err,
   input  wire logic       init_err,
   input  wire logic [3:0] phys_err,
   input  wire logic       bit_window,
   input  wire logic       line_hi,
   input  wire logic       line_lo,
   input  wire logic       fwd_read,
   input  wire logic       new_cmd_any,
   input  wire logic [3:0] clr,
   output logic      [7:0] phys_reg,
   output logic      [7:0] rc_reg,
   output logic      [7:0] rsp_reg,
   output logic      [7:0] tr_reg,
   output logic      [3:0] evt,
   output logic            process_en
);
   typedef struct packed {
      logic [5:0] phys;
      logic [5:0] rc;
      logic [4:0] rsp;
      logic       wt;
      logic       in_frame;
      logic       cur_resp;
      logic       cur_read;
      logic       hunt;
      logic       seen_hi;
      logic       seen_lo;
      logic       win_d;
      logic       pend;
      logic [3:0] evt;
   } dcf_link_type;

   dcf_link_type s_r;
   dcf_link_type s_nxt;

   always_comb begin
      logic [5:0] ps;
      logic [5:0] rcs;
      logic [4:0] rsps;
      logic       ws;
      logic       stray;
      ps    = '0;
      rcs   = '0;
      rsps  = '0;
      ws    = 1'b0;
      stray = 1'b0;
      s_nxt = s_r;
      ps[3:0] = phys_err;
      if (byte_err) begin
         ps[dcf_pkg::PHYS_BYTE] = 1'b1;
      end
      // Missing bit: window closed with neither level seen
      s_nxt.win_d = bit_window;
      if (bit_window && !s_r.win_d) begin
         s_nxt.seen_hi = line_hi;
         s_nxt.seen_lo = line_lo;
      end else if (bit_window) begin
         s_nxt.seen_hi = s_r.seen_hi | line_hi;
         s_nxt.seen_lo = s_r.seen_lo | line_lo;
      end
      if (s_r.win_d && !bit_window && !s_r.seen_hi && !s_r.seen_lo) begin
         ps[dcf_pkg::PHYS_MISS] = 1'b1;
      end
      if (init_err) begin
         rcs[dcf_pkg::RX_INIT] = 1'b1;
         s_nxt.hunt     = 1'b1;
         s_nxt.in_frame = 1'b0;
      end else if (s_r.hunt) begin
         // Bytes pass through unprocessed until a frame start arrives
         if (frame_start) begin
            s_nxt.hunt     = 1'b0;
            s_nxt.in_frame = 1'b1;
            s_nxt.cur_resp = frame_is_resp;
            s_nxt.cur_read = frame_is_read;
         end
      end else begin
         if (frame_start && s_r.in_frame) begin
            if (s_r.cur_resp) begin
               rsps[dcf_pkg::RX_SOF] = 1'b1;
            end else begin
               rcs[dcf_pkg::RX_SOF] = 1'b1;
            end
         end
         if (frame_start) begin
            s_nxt.in_frame = 1'b1;
            s_nxt.cur_resp = frame_is_resp;
            s_nxt.cur_read = frame_is_read;
         end
         if (byte_err) begin
            if (s_r.cur_resp) begin
               rsps[dcf_pkg::RX_BYTE] = 1'b1;
            end else begin
               rcs[dcf_pkg::RX_BYTE] = 1'b1;
            end
         end
         if (crc_err && s_r.in_frame) begin
            if (s_r.cur_resp) begin
               rsps[dcf_pkg::RX_CRC] = 1'b1;
            end else begin
               rcs[dcf_pkg::RX_CRC] = 1'b1;
            end
         end
         if (frame_end && s_r.in_frame && !crc_err) begin
            s_nxt.in_frame = frame_start;
            stray = (s_r.cur_resp == (dir_sel ~^ UPPER));
            if (s_r.cur_resp) begin
               rsps[dcf_pkg::RX_STRAY] = stray;
               rsps[dcf_pkg::RX_DROP]  = !stray & rsp_tx_dis;
            end else begin
               rcs[dcf_pkg::RX_STRAY] = stray;
               rcs[dcf_pkg::RX_DROP]  = !stray & s_r.cur_read & cmd_tx_dis;
            end
         end
      end
      // Wait for a forwarded read answer
      if (fwd_read) begin
         s_nxt.pend = 1'b1;
      end else if (s_r.pend && new_cmd_any) begin
         ws         = 1'b1;
         s_nxt.pend = 1'b0;
      end else if (frame_end && s_r.cur_resp && s_r.in_frame) begin
         s_nxt.pend = 1'b0;
      end
      s_nxt.phys = (s_r.phys & ~{6{clr[0]}}) | ps;
      s_nxt.rc   = (s_r.rc & ~{6{clr[1]}}) | rcs;
      s_nxt.rsp  = (s_r.rsp & ~{5{clr[2]}}) | rsps;
      s_nxt.wt   = (s_r.wt & ~clr[3]) | ws;
      s_nxt.evt  = {ws, |rsps, |rcs, |ps};
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign phys_reg   = {2'h0, s_r.phys};
   assign rc_reg     = {2'h0, s_r.rc};
   assign rsp_reg    = {3'h0, s_r.rsp};
   assign tr_reg     = {7'h00, s_r.wt};
   assign evt        = s_r.evt;
   assign process_en = !s_r.hunt;
endmodule

// ===== rtl/dcf_pkg.sv
// Constants shared by the communication fault flag block
package dcf_pkg;
   localparam int ADDR_W = 12;
   localparam int IDX_W  = 10;
   // Register indices; byte address is four times the index
   localparam logic [9:0] IDX_HOST_TR  = 10'h299;
   localparam logic [9:0] IDX_UP_PHYS  = 10'h29a;
   localparam logic [9:0] IDX_UP_RC    = 10'h29b;
   localparam logic [9:0] IDX_UP_RSP   = 10'h29c;
   localparam logic [9:0] IDX_UP_TR    = 10'h29d;
   localparam logic [9:0] IDX_LOW_PHYS = 10'h29e;
   localparam logic [9:0] IDX_LOW_RC   = 10'h29f;
   localparam logic [9:0] IDX_LOW_RSP  = 10'h2a0;
   localparam logic [9:0] IDX_LOW_TR   = 10'h2a1;
   localparam logic [9:0] IDX_NVM      = 10'h2a2;
   localparam logic [9:0] IDX_CTRL     = 10'h2a8;
   localparam logic [9:0] IDX_STAT     = 10'h2a9;
   localparam logic [9:0] IDX_MASK     = 10'h2aa;
   // Reset values
   localparam logic [7:0] FAULT_RESET  = 8'h00;
   localparam logic [4:0] CTRL_RESET   = 5'h1c;
   localparam logic [9:0] STAT_RESET   = 10'h000;
   localparam logic [9:0] MASK_RESET   = 10'h000;
   // Link control bits
   localparam int CTRL_DIR     = 0;
   localparam int CTRL_BASE    = 1;
   localparam int CTRL_HOST_TX = 2;
   localparam int CTRL_UP_TX   = 3;
   localparam int CTRL_LOW_TX  = 4;
   // Physical layer fault fields
   localparam int PHYS_BIT   = 0;
   localparam int PHYS_PRE1  = 1;
   localparam int PHYS_PRE2  = 2;
   localparam int PHYS_ORDER = 3;
   localparam int PHYS_MISS  = 4;
   localparam int PHYS_BYTE  = 5;
   // Receive fault fields, shared by command and response registers; RX_INIT is in the command register only
   localparam int RX_CRC   = 0;
   localparam int RX_STRAY = 1;
   localparam int RX_BYTE  = 2;
   localparam int RX_SOF   = 3;
   localparam int RX_DROP  = 4;
   localparam int RX_INIT  = 5;
   // Transmit fault fields
   localparam int TR_WAIT = 0;
   localparam int TR_SOF  = 1;
   // Memory load fault fields
   localparam int NVM_GBL  = 0;
   localparam int NVM_FACT = 1;
   localparam int NVM_CUST = 2;
   // Interrupt status bits, one per fault register
   localparam int NUM_STAT  = 10;
   localparam int ST_HOST   = 0;
   localparam int ST_LINK0  = 1;
   localparam int ST_NVM    = 9;
   localparam int ST_PER_LK = 4;
endpackage

// ===== rtl/dcf_sync.sv
// Two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
module dcf_sync #(
   parameter int WIDTH = 4
) (
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } dcf_sync_type;

   dcf_sync_type s_r;
   dcf_sync_type s_nxt;

   always_comb begin
      s_nxt    = s_r;
      s_nxt.s1 = d;
      s_nxt.s2 = s_r.s1;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign q = s_r.s2;
endmodule

// ===== rtl/dcf_top.sv
// APB register bank of communication fault flags with interrupt
`timescale 1ns/1ps
module dcf_top (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        host_tx_busy,
   input  wire logic        host_break,
   input  wire logic        host_new_cmd,
   input  wire logic        host_fwd_read,
   input  wire logic        host_resp_done,
   input  wire logic [1:0]  link_frame_start,
   input  wire logic [1:0]  link_frame_is_resp,
   input  wire logic [1:0]  link_frame_is_read,
   input  wire logic [1:0]  link_frame_end,
   input  wire logic [1:0]  link_crc_err,
   input  wire logic [1:0]  link_byte_err,
   input  wire logic [1:0]  link_init_err,
   input  wire logic [3:0]  up_phys_err,
   input  wire logic [3:0]  low_phys_err,
   input  wire logic [1:0]  link_bit_window,
   input  wire logic [1:0]  link_line_hi,
   input  wire logic [1:0]  link_line_lo,
   input  wire logic [1:0]  link_fwd_read,
   input  wire logic [2:0]  nvm_load_err,
   output logic             irq,
   output logic [1:0]       link_process_en
);
   ////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [1:0]  host_tr;
      logic        host_pend;
      logic [2:0]  nvm;
      logic [4:0]  ctrl;
      logic [9:0]  stat;
      logic [9:0]  mask;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        irq;
   } dcf_top_type;

   dcf_top_type s_r;
   dcf_top_type s_nxt;

   logic [9:0] idx;
   logic       wr_take;
   logic [9:0] stat_clr;
   logic [3:0] line_q;
   logic       dir;
   logic       base;
   logic       new_cmd_any;
   logic [1:0] cmd_tx_dis;
   logic [1:0] rsp_tx_dis;
   logic [3:0] phys_err [2];
   logic [7:0] phys_reg [2];
   logic [7:0] rc_reg   [2];
   logic [7:0] rsp_reg  [2];
   logic [7:0] tr_reg   [2];
   logic [3:0] lk_evt   [2];

   assign idx     = paddr[11:2];
   assign wr_take = psel & penable & s_r.pready & pwrite & !s_r.pslverr;
   assign stat_clr = (wr_take && idx == dcf_pkg::IDX_STAT) ? pwdata[9:0] : 10'h000;
   assign dir     = s_r.ctrl[dcf_pkg::CTRL_DIR];
   assign base    = s_r.ctrl[dcf_pkg::CTRL_BASE];
   assign phys_err[0] = up_phys_err;
   assign phys_err[1] = low_phys_err;

   ////////////////////////////////////////////////////////////////////
   // Line level pins come from the link receivers
   dcf_sync #(
      .WIDTH (4)
   ) u_sync (
      .clk  (clk),
      .srst (srst),
      .d    ({link_line_lo, link_line_hi}),
      .q    (line_q)
   );

   ////////////////////////////////////////////////////////////////////
   // Onward transmitter state seen by each port
   assign new_cmd_any = host_break | host_new_cmd |
                        |(link_frame_start & ~link_frame_is_resp);
   assign cmd_tx_dis[0] = dir & !s_r.ctrl[dcf_pkg::CTRL_UP_TX];
   assign cmd_tx_dis[1] = !dir & !s_r.ctrl[dcf_pkg::CTRL_LOW_TX];
   assign rsp_tx_dis[0] = !dir & (base ? !s_r.ctrl[dcf_pkg::CTRL_HOST_TX]
                                       : !s_r.ctrl[dcf_pkg::CTRL_LOW_TX]);
   assign rsp_tx_dis[1] = dir & (base ? !s_r.ctrl[dcf_pkg::CTRL_HOST_TX]
                                      : !s_r.ctrl[dcf_pkg::CTRL_UP_TX]);

   ////////////////////////////////////////////////////////////////////
   // Port 0 is the upper link port, port 1 the lower
   generate
      for (genvar p = 0; p < 2; p++) begin : g_link
         dcf_link_port #(
            .UPPER (p == 0)
         ) u_port (
            .clk           (clk),
            .srst          (srst),
            .dir_sel       (dir),
            .cmd_tx_dis    (cmd_tx_dis[p]),
            .rsp_tx_dis    (rsp_tx_dis[p]),
            .frame_start   (link_frame_start[p]),
            .frame_is_resp (link_frame_is_resp[p]),
            .frame_is_read (link_frame_is_read[p]),
            .frame_end     (link_frame_end[p]),
            .crc_err       (link_crc_err[p]),
            .byte_err      (link_byte_err[p]),
            .init_err      (link_init_err[p]),
            .phys_err      (phys_err[p]),
            .bit_window    (link_bit_window[p]),
            .line_hi       (line_q[p]),
            .line_lo       (line_q[p+2]),
            .fwd_read      (link_fwd_read[p]),
            .new_cmd_any   (new_cmd_any),
            .clr           (stat_clr[dcf_pkg::ST_LINK0 + p*dcf_pkg::ST_PER_LK +: 4]),
            .phys_reg      (phys_reg[p]),
            .rc_reg        (rc_reg[p]),
            .rsp_reg       (rsp_reg[p]),
            .tr_reg        (tr_reg[p]),
            .evt           (lk_evt[p]),
            .process_en    (link_process_en[p])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [1:0] hs;
      logic [9:0] st_set;
      logic [7:0] rd;
      logic       hit;
      hs     = '0;
      st_set = '0;
      rd     = '0;
      hit    = 1'b1;
      s_nxt  = s_r;

      // Host serial transmit faults
      if (host_tx_busy && host_break) begin
         hs[dcf_pkg::TR_SOF] = 1'b1;
      end
      if (host_fwd_read) begin
         s_nxt.host_pend = 1'b1;
      end else if (s_r.host_pend && (host_break || host_new_cmd)) begin
         hs[dcf_pkg::TR_WAIT] = 1'b1;
         s_nxt.host_pend      = 1'b0;
      end else if (host_resp_done) begin
         s_nxt.host_pend = 1'b0;
      end
      s_nxt.host_tr = (s_r.host_tr & ~{2{stat_clr[dcf_pkg::ST_HOST]}}) | hs;
      s_nxt.nvm     = (s_r.nvm & ~{3{stat_clr[dcf_pkg::ST_NVM]}}) | nvm_load_err;

      // Sticky status, set wins over write-one-to-clear
      st_set[dcf_pkg::ST_HOST]  = |hs;
      st_set[dcf_pkg::ST_NVM]   = |nvm_load_err;
      st_set[4:1]               = lk_evt[0];
      st_set[8:5]               = lk_evt[1];
      s_nxt.stat = (s_r.stat & ~stat_clr) | st_set;

      if (wr_take && idx == dcf_pkg::IDX_CTRL) begin
         s_nxt.ctrl = pwdata[4:0];
      end
      if (wr_take && idx == dcf_pkg::IDX_MASK) begin
         s_nxt.mask = pwdata[9:0];
      end

      // Read decode in setup, answered in the first access cycle
      case (idx)
         dcf_pkg::IDX_HOST_TR: begin
            rd = {6'h00, s_r.host_tr};
         end
         dcf_pkg::IDX_UP_PHYS: begin
            rd = phys_reg[0];
         end
         dcf_pkg::IDX_UP_RC: begin
            rd = rc_reg[0];
         end
         dcf_pkg::IDX_UP_RSP: begin
            rd = rsp_reg[0];
         end
         dcf_pkg::IDX_UP_TR: begin
            rd = tr_reg[0];
         end
         dcf_pkg::IDX_LOW_PHYS: begin
            rd = phys_reg[1];
         end
         dcf_pkg::IDX_LOW_RC: begin
            rd = rc_reg[1];
         end
         dcf_pkg::IDX_LOW_RSP: begin
            rd = rsp_reg[1];
         end
         dcf_pkg::IDX_LOW_TR: begin
            rd = tr_reg[1];
         end
         dcf_pkg::IDX_NVM: begin
            rd = {5'h00, s_r.nvm};
         end
         default: begin
            hit = 1'b0;
         end
      endcase

      s_nxt.pready  = psel & !penable;
      s_nxt.pslverr = 1'b0;
      if (psel && !penable) begin
         s_nxt.prdata = {24'h000000, rd};
         if (idx == dcf_pkg::IDX_CTRL) begin
            s_nxt.prdata = {27'h0000000, s_r.ctrl};
         end else if (idx == dcf_pkg::IDX_STAT) begin
            s_nxt.prdata = {22'h000000, s_r.stat};
         end else if (idx == dcf_pkg::IDX_MASK) begin
            s_nxt.prdata = {22'h000000, s_r.mask};
         end else begin
            s_nxt.pslverr = !hit;
         end
      end

      s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_r         <= '0;
         s_r.ctrl    <= dcf_pkg::CTRL_RESET;
         s_r.stat    <= dcf_pkg::STAT_RESET;
         s_r.mask    <= dcf_pkg::MASK_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata  = s_r.prdata;
   assign pready  = s_r.pready;
   assign pslverr = s_r.pslverr;
   assign irq     = s_r.irq;
endmodule
